// ==== src/memref_arith_store_exec.sv ====
// sequencer and datapath for the subtract, logical difference, store and
// replace group of memory-reference instructions
// assumes a storage port on the same clock that answers each request with
// a one-cycle acknowledge; the first instruction word is handed in at start
// limitation: indexed replace-subtract-one is flagged unsupported, not run
//
// What this block does
// - indexed address is second word plus index word
// - zero short field selects direct addressing
// - subtract adds ones-extended complement of operand
// - indexed subtract makes four ordered references
// - logical difference xors low twelve bits only
// - direct difference and store use three references
// - store writes low twelve accumulator bits
// - indexed store makes four ordered references
// - replace-add adds zero-extended operand, writes back
// - direct replace-add uses four references
// - indexed replace-add: five references, hold updated
// - replace-add-one presets accumulator to plus one
// - replace-subtract-one presets accumulator to minus one
// - direct replace-one forms use four references
// - indexed replace-add-one: five references, fifth fetches
`timescale 1ns/1ps
`default_nettype none
`include "memref_defs.svh"
module memref_arith_store_exec (
    input  wire logic               CLK_I,
    input  wire logic               RST_I,
    input  wire logic               START_I,
    input  wire logic [11:0]        INSTR_I,
    input  wire logic [11:0]        PADDR_I,
    input  wire logic               ACC_WR_I,
    input  wire logic [17:0]        ACC_DATA_I,
    input  wire logic [11:0]        MEM_RDATA_I,
    input  wire logic               MEM_ACK_I,
    output var  logic               MEM_REQ_O,
    output var  logic               MEM_WE_O,
    output var  logic [11:0]        MEM_ADDR_O,
    output var  logic [11:0]        MEM_WDATA_O,
    output var  logic [17:0]        ACC_O,
    output var  logic               BUSY_O,
    output var  logic               DONE_O,
    output var  logic               UNSUPPORTED_O,
    output var  logic [11:0]        NEXT_INSTR_O,
    output var  memref_pkg::op_type LAST_OP_O,
    output var  logic [2:0]         REF_COUNT_O
);
    import memref_pkg::*;

    state_type   state;
    op_type      op;
    op_type      start_op;
    logic        indexed;
    logic        start_indexed;
    logic        start_ok;
    logic [5:0]  short_field;
    logic [5:0]  start_short;
    logic [11:0] hold_q;
    logic [11:0] buffer_x;
    logic [11:0] next_paddr;
    logic [2:0]  refs;
    logic        ack;
    logic        is_replace;
    logic        operand_read;

    ones_add_if add_bus ();

    ones_adder u_adder (
        .port (add_bus.calc)
    );

    // the function code picks the operation; short field picks addressing
    always_comb begin
        // pure decode; nothing is held unless the start is taken
        start_short = INSTR_I[`SHORT_HI:`SHORT_LO];
        start_indexed = (start_short != `SHORT_ZERO);
        case (INSTR_I[`FN_HI:`FN_LO])
            `FN_SUB:   start_op = OP_SUB;
            `FN_LDIFF: start_op = OP_LDIFF;
            `FN_STORE: start_op = OP_STORE;
            `FN_RADD:  start_op = OP_RADD;
            `FN_RADD1: start_op = OP_RADD1;
            `FN_RSUB1: start_op = OP_RSUB1;
            default:   start_op = OP_NONE;
        endcase
        // indexed replace-subtract-one is handled elsewhere in the processor
        start_ok = (start_op != OP_NONE) && !(start_op == OP_RSUB1 && start_indexed);
    end

    // an ack while no request stands is ignored
    assign ack          = MEM_REQ_O && MEM_ACK_I;
    assign is_replace   = (op == OP_RADD) || (op == OP_RADD1) || (op == OP_RSUB1);
    assign operand_read = (state == ST_OPERAND) && (op != OP_STORE);

    // accumulator path: subtract uses the ones-extended complement,
    // every other add uses the zero-extended operand
    always_comb begin
        add_bus.a18 = ACC_O;
        if (op == OP_SUB) begin
            add_bus.b18 = {`EXT_ONES, ~MEM_RDATA_I};
        end else begin
            add_bus.b18 = {`EXT_ZEROS, MEM_RDATA_I};
        end
    end

    // address path: hold register plus the index word just read
    assign add_bus.a12 = hold_q;
    assign add_bus.b12 = MEM_RDATA_I;

    // sequencing of storage references
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            state       <= ST_IDLE;
            op          <= OP_NONE;
            indexed     <= 1'b0;
            short_field <= `SHORT_ZERO;
            next_paddr  <= `WORD_ZERO;
            refs        <= `REFS_ZERO;
            MEM_REQ_O   <= 1'b0;
            MEM_WE_O    <= 1'b0;
            MEM_ADDR_O  <= `WORD_ZERO;
            MEM_WDATA_O <= `WORD_ZERO;
        end else begin
            // counts acknowledged references of the running instruction
            if (ack) begin
                refs <= refs + `REFS_STEP;
            end
            case (state)
                ST_IDLE: begin
                    // a start that is not in the group runs no reference
                    if (START_I && start_ok) begin
                        state       <= ST_RD_SECOND;
                        op          <= start_op;
                        indexed     <= start_indexed;
                        short_field <= start_short;
                        next_paddr  <= PADDR_I + `WORD_STEP;
                        refs        <= `REFS_ZERO;
                        MEM_REQ_O   <= 1'b1;
                        MEM_WE_O    <= 1'b0;
                        MEM_ADDR_O  <= PADDR_I;
                    end
                end
                ST_RD_SECOND: begin
                    if (ack) begin
                        if (indexed) begin
                            state      <= ST_RD_INDEX;
                            MEM_ADDR_O <= {`SHORT_ZERO, short_field};
                            MEM_WE_O   <= 1'b0;
                        end else begin
                            state       <= ST_OPERAND;
                            MEM_ADDR_O  <= MEM_RDATA_I;
                            MEM_WE_O    <= (op == OP_STORE);
                            MEM_WDATA_O <= ACC_O[11:0];
                        end
                    end
                end
                ST_RD_INDEX: begin
                    if (ack) begin
                        state       <= ST_OPERAND;
                        MEM_ADDR_O  <= add_bus.s12;
                        MEM_WE_O    <= (op == OP_STORE);
                        MEM_WDATA_O <= ACC_O[11:0];
                    end
                end
                ST_OPERAND: begin
                    if (ack) begin
                        if (is_replace) begin
                            // write-back goes to the hold register address,
                            // which the indexed forms refresh in this cycle
                            state       <= ST_WRITE_BACK;
                            MEM_WE_O    <= 1'b1;
                            MEM_WDATA_O <= add_bus.s18[11:0];
                            if (indexed) begin
                                MEM_ADDR_O <= MEM_ADDR_O;
                            end else begin
                                MEM_ADDR_O <= hold_q;
                            end
                        end else begin
                            // subtract, difference and store go on to the fetch
                            state      <= ST_FETCH;
                            MEM_WE_O   <= 1'b0;
                            MEM_ADDR_O <= next_paddr;
                        end
                    end
                end
                ST_WRITE_BACK: begin
                    if (ack) begin
                        state      <= ST_FETCH;
                        MEM_WE_O   <= 1'b0;
                        MEM_ADDR_O <= next_paddr;
                    end
                end
                ST_FETCH: begin
                    // request drops only after the fetch ack, never in between
                    if (ack) begin
                        state     <= ST_IDLE;
                        MEM_REQ_O <= 1'b0;
                        MEM_WE_O  <= 1'b0;
                    end
                end
                default: begin
                    state     <= ST_IDLE;
                    MEM_REQ_O <= 1'b0;
                    MEM_WE_O  <= 1'b0;
                end
            endcase
        end
    end

    // operand buffer and address-hold registers
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            buffer_x <= `WORD_ZERO;
            hold_q   <= `WORD_ZERO;
        end else if (ack) begin
            case (state)
                ST_RD_SECOND: begin
                    buffer_x <= MEM_RDATA_I;
                    hold_q   <= MEM_RDATA_I;
                end
                ST_RD_INDEX: begin
                    buffer_x <= MEM_RDATA_I;
                end
                ST_OPERAND: begin
                    // a store reference leaves the buffer alone
                    if (!MEM_WE_O) begin
                        buffer_x <= MEM_RDATA_I;
                    end
                    // for the indexed replace forms only, hold picks up the indexed sum as the operand is read
                    if (indexed && is_replace) begin
                        hold_q <= MEM_ADDR_O;
                    end
                end
                default: begin
                    buffer_x <= buffer_x;
                end
            endcase
        end
    end

    // accumulator
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            ACC_O <= `ACC_RESET;
        end else if (state == ST_IDLE) begin
            if (START_I && start_ok && start_op == OP_RADD1) begin
                ACC_O <= `ACC_PLUS1;
            end else if (START_I && start_ok && start_op == OP_RSUB1) begin
                ACC_O <= `ACC_MINUS1;
            end else if (ACC_WR_I) begin
                // loads from the rest of the processor only between instructions
                ACC_O <= ACC_DATA_I;
            end
        end else if (ack && operand_read) begin
            case (op)
                OP_LDIFF: begin
                    ACC_O <= {ACC_O[17:12], ACC_O[11:0] ^ MEM_RDATA_I};
                end
                // minus zero is kept as it comes; no normalising
                OP_SUB, OP_RADD, OP_RADD1, OP_RSUB1: begin
                    ACC_O <= add_bus.s18;
                end
                default: begin
                    ACC_O <= ACC_O;
                end
            endcase
        end
    end

    // status toward the rest of the processor
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            BUSY_O        <= 1'b0;
            DONE_O        <= 1'b0;
            UNSUPPORTED_O <= 1'b0;
            NEXT_INSTR_O  <= `WORD_ZERO;
            LAST_OP_O     <= OP_NONE;
            REF_COUNT_O   <= `REFS_ZERO;
        end else begin
            DONE_O        <= 1'b0;
            UNSUPPORTED_O <= 1'b0;
            if (state == ST_IDLE && START_I) begin
                BUSY_O        <= start_ok;
                UNSUPPORTED_O <= !start_ok;
            end
            // done, next word, operation and count change on one edge
            if (state == ST_FETCH && ack) begin
                BUSY_O       <= 1'b0;
                DONE_O       <= 1'b1;
                NEXT_INSTR_O <= MEM_RDATA_I;
                LAST_OP_O    <= op;
                // three, four or five references depending on the form
                REF_COUNT_O  <= refs + `REFS_STEP;
            end
        end
    end

endmodule // memref_arith_store_exec
`default_nettype wire

// ==== inc/memref_defs.svh ====
// constants for the memory-reference arithmetic and store sequencer
// assumes 12-bit storage words and an 18-bit accumulator
`ifndef MEMREF_DEFS_SVH
`define MEMREF_DEFS_SVH

// instruction word fields
`define FN_HI       11
`define FN_LO       6
`define SHORT_HI    5
`define SHORT_LO    0
`define SHORT_ZERO  6'h00

// function codes of the group
`define FN_SUB      6'h2A
`define FN_LDIFF    6'h2B
`define FN_STORE    6'h2C
`define FN_RADD     6'h2D
`define FN_RADD1    6'h2E
`define FN_RSUB1    6'h2F

// operand extension and accumulator presets
`define EXT_ONES    6'h3F
`define EXT_ZEROS   6'h00
`define ACC_PLUS1   18'h00001
`define ACC_MINUS1  18'h3FFFE
`define ACC_RESET   18'h00000
`define WORD_ZERO   12'h000
`define WORD_STEP   12'h001
`define REFS_ZERO   3'h0
`define REFS_STEP   3'h1

`endif

// ==== inc/memref_pkg.sv ====
// types shared by the sequencer, its checker and the bench
// assumes the constants header is included where numbers are needed
`default_nettype none
package memref_pkg;

    typedef enum logic [2:0] {
        OP_SUB,
        OP_LDIFF,
        OP_STORE,
        OP_RADD,
        OP_RADD1,
        OP_RSUB1,
        OP_NONE
    } op_type;

    typedef enum {
        ST_IDLE,
        ST_RD_SECOND,
        ST_RD_INDEX,
        ST_OPERAND,
        ST_WRITE_BACK,
        ST_FETCH
    } state_type;

endpackage
`default_nettype wire

// ==== inc/ones_add_if.sv ====
// operand and sum wires between the sequencer and the one's complement adder
// assumes both ends sit on the same clock; the adder is purely combinational
`timescale 1ns/1ps
`default_nettype none
interface ones_add_if;
    logic [17:0] a18;
    logic [17:0] b18;
    logic [17:0] s18;
    logic [11:0] a12;
    logic [11:0] b12;
    logic [11:0] s12;

    modport user (output a18, output b18, output a12, output b12,
                  input s18, input s12);
    modport calc (input a18, input b18, input a12, input b12,
                  output s18, output s12);
endinterface
`default_nettype wire

// ==== src/ones_adder.sv ====
// one's complement adders: 18-bit accumulator path and 12-bit address path
// assumes operands are stable within the cycle; no state inside
`timescale 1ns/1ps
`default_nettype none
module ones_adder (
    ones_add_if.calc port
);
    logic [18:0] raw18;
    logic [12:0] raw12;

    // end-around carry: the top carry re-enters at bit zero
    assign raw18    = {1'b0, port.a18} + {1'b0, port.b18};
    assign port.s18 = raw18[17:0] + {17'h00000, raw18[18]};

    assign raw12    = {1'b0, port.a12} + {1'b0, port.b12};
    assign port.s12 = raw12[11:0] + {11'h000, raw12[12]};
endmodule // ones_adder
`default_nettype wire

// ==== test/memref_mem_model.sv ====
// storage partner: 4096 words of 12 bits, one-cycle ack after a set wait
// assumes the bench preloads words by hierarchy; no reset of contents
`timescale 1ns/1ps
`default_nettype none
module memref_mem_model (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        req_i,
    input  wire logic        we_i,
    input  wire logic [11:0] addr_i,
    input  wire logic [11:0] wdata_i,
    input  wire logic [1:0]  wait_i,
    output var  logic [11:0] rdata_o,
    output var  logic        ack_o
);
    logic [11:0] words [0:4095];
    logic [1:0]  cnt;
    // read data toggles when not acked, so stale values never look valid
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ack_o   <= 1'b0;
            rdata_o <= 12'h000;
            cnt     <= 2'h0;
        end else if (req_i && !ack_o && cnt >= wait_i) begin
            ack_o   <= 1'b1;
            cnt     <= 2'h0;
            rdata_o <= we_i ? ~rdata_o : words[addr_i];
            if (we_i) begin
                words[addr_i] <= wdata_i;
            end
        end else begin
            ack_o   <= 1'b0;
            rdata_o <= ~rdata_o;
            if (req_i && !ack_o) begin
                cnt <= cnt + 2'h1;
            end
        end
    end
endmodule // memref_mem_model
`default_nettype wire

// ==== test/memref_checker.sv ====
// assertions on the sequencer's ports
// assumes one clock domain, async active-high reset
`timescale 1ns/1ps
`default_nettype none
module memref_checker import memref_pkg::*; (
    input wire logic        CLK_I,
    input wire logic        RST_I,
    input wire logic        START_I,
    input wire logic [11:0] INSTR_I,
    input wire logic [11:0] PADDR_I,
    input wire logic        MEM_ACK_I,
    input wire logic        MEM_REQ_O,
    input wire logic        MEM_WE_O,
    input wire logic [11:0] MEM_ADDR_O,
    input wire logic [11:0] MEM_WDATA_O,
    input wire logic [17:0] ACC_O,
    input wire logic        BUSY_O,
    input wire logic        DONE_O,
    input wire logic        UNSUPPORTED_O,
    input wire logic [2:0]  REF_COUNT_O
);
    logic [5:0]  fn_s;
    logic        ind_s;
    logic [11:0] pc_s;
    logic [17:0] acc_s;
    logic [2:0]  cnt;
    logic        take;
    logic        ok_fn;
    assign take  = START_I && !BUSY_O;
    assign ok_fn = INSTR_I[11:6] inside {[6'h2A:6'h2F]}
                   && !(INSTR_I[11:6] == 6'h2F && INSTR_I[5:0] != 6'h00);
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            fn_s  <= 6'h00;
            ind_s <= 1'b0;
            pc_s  <= 12'h000;
            acc_s <= 18'h00000;
            cnt   <= 3'h0;
        end else if (take) begin
            fn_s  <= INSTR_I[11:6];
            ind_s <= INSTR_I[5:0] != 6'h00;
            pc_s  <= PADDR_I;
            acc_s <= ACC_O;
            cnt   <= 3'h0;
        end else if (MEM_REQ_O && MEM_ACK_I) begin
            cnt <= cnt + 3'h1;
        end
    end
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RST_I);
    sequence s_take_ok;
        take && ok_fn;
    endsequence
    sequence s_read_then_write;
        MEM_REQ_O && MEM_ACK_I && !MEM_WE_O && fn_s >= 6'h2D ##1 MEM_WE_O;
    endsequence
    AST_START: assert property (s_take_ok |=> MEM_REQ_O && !MEM_WE_O && BUSY_O
        && MEM_ADDR_O == $past(PADDR_I)) else $error("first reference wrong");
    AST_UNSUP: assert property (take && !ok_fn |=> UNSUPPORTED_O && !MEM_REQ_O)
        else $error("unsupported code not flagged");
    AST_HOLD: assert property (MEM_REQ_O && !MEM_ACK_I |=> MEM_REQ_O && $stable(MEM_ADDR_O)
        && $stable(MEM_WE_O) && $stable(MEM_WDATA_O)) else $error("request moved early");
    AST_WDATA: assert property (MEM_REQ_O && MEM_WE_O |-> MEM_WDATA_O == ACC_O[11:0])
        else $error("write data not low accumulator");
    AST_WB_ADDR: assert property (s_read_then_write |-> MEM_ADDR_O == $past(MEM_ADDR_O))
        else $error("write-back address differs");
    AST_COUNT: assert property (DONE_O |-> REF_COUNT_O == cnt
        && cnt == 3 + ind_s + (fn_s >= 6'h2D)) else $error("reference count wrong");
    AST_FETCH: assert property (DONE_O |-> $past(MEM_ADDR_O) == pc_s + 12'h001
        && !$past(MEM_WE_O) && !BUSY_O && !MEM_REQ_O) else $error("fetch wrong");
    AST_KEEP: assert property (DONE_O && fn_s inside {6'h2B, 6'h2C}
        |-> ACC_O[17:12] == acc_s[17:12] && (fn_s == 6'h2B || ACC_O == acc_s))
        else $error("accumulator bits disturbed");
    AST_PRESET: assert property (s_take_ok ##0 INSTR_I[11:6] >= 6'h2E
        |=> ACC_O == (fn_s == 6'h2E ? 18'h00001 : 18'h3FFFE)) else $error("preset wrong");
endmodule // memref_checker
bind memref_arith_store_exec memref_checker u_chk (.CLK_I(CLK_I), .RST_I(RST_I),
    .START_I(START_I), .INSTR_I(INSTR_I), .PADDR_I(PADDR_I), .MEM_ACK_I(MEM_ACK_I),
    .MEM_REQ_O(MEM_REQ_O), .MEM_WE_O(MEM_WE_O), .MEM_ADDR_O(MEM_ADDR_O),
    .MEM_WDATA_O(MEM_WDATA_O), .ACC_O(ACC_O), .BUSY_O(BUSY_O), .DONE_O(DONE_O),
    .UNSUPPORTED_O(UNSUPPORTED_O), .REF_COUNT_O(REF_COUNT_O));
`default_nettype wire

// ==== test/tb.sv ====
// self-checking bench: random instructions of the group against a model
// assumes the storage partner model and the bound checker
`timescale 1ns/1ps
`default_nettype none
module tb;
    import memref_pkg::*;
    logic        CLK_I, RST_I, START_I, ACC_WR_I, MEM_ACK_I;
    logic        MEM_REQ_O, MEM_WE_O, BUSY_O, DONE_O, UNSUPPORTED_O;
    logic [11:0] INSTR_I, PADDR_I, MEM_RDATA_I, MEM_ADDR_O, MEM_WDATA_O, NEXT_INSTR_O;
    logic [17:0] ACC_DATA_I, ACC_O;
    logic [2:0]  REF_COUNT_O;
    op_type      LAST_OP_O;
    logic [1:0]  mem_wait;
    logic [15:0] seed;
    int          errors, cmp_count;
    logic [12:0] ref_q [$];
    logic        hung;
    memref_arith_store_exec DUT (.CLK_I(CLK_I), .RST_I(RST_I), .START_I(START_I),
        .INSTR_I(INSTR_I), .PADDR_I(PADDR_I), .ACC_WR_I(ACC_WR_I), .ACC_DATA_I(ACC_DATA_I),
        .MEM_RDATA_I(MEM_RDATA_I), .MEM_ACK_I(MEM_ACK_I), .MEM_REQ_O(MEM_REQ_O),
        .MEM_WE_O(MEM_WE_O), .MEM_ADDR_O(MEM_ADDR_O), .MEM_WDATA_O(MEM_WDATA_O),
        .ACC_O(ACC_O), .BUSY_O(BUSY_O), .DONE_O(DONE_O), .UNSUPPORTED_O(UNSUPPORTED_O),
        .NEXT_INSTR_O(NEXT_INSTR_O), .LAST_OP_O(LAST_OP_O), .REF_COUNT_O(REF_COUNT_O));
    memref_mem_model u_mem (.clk_i(CLK_I), .rst_i(RST_I), .req_i(MEM_REQ_O),
        .we_i(MEM_WE_O), .addr_i(MEM_ADDR_O), .wdata_i(MEM_WDATA_O), .wait_i(mem_wait),
        .rdata_o(MEM_RDATA_I), .ack_o(MEM_ACK_I));
    initial begin
        CLK_I = 1'b0;
        forever #5 CLK_I = ~CLK_I;
    end
    // end-around carry; a second wrap cannot happen
    function automatic logic [17:0] a18(input logic [17:0] a, input logic [17:0] b);
        logic [18:0] s;
        s = a + b;
        return s[17:0] + s[18];
    endfunction
    function automatic logic [11:0] a12(input logic [11:0] a, input logic [11:0] b);
        logic [12:0] s;
        s = a + b;
        return s[11:0] + s[12];
    endfunction
    function automatic logic [15:0] step();
        seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
        return seed;
    endfunction
    task automatic check(input logic [17:0] seen, input logic [17:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        $display("comparisons %0d errors %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // every acknowledged reference against the expected order {write, address}
    always @(negedge CLK_I) begin
        if (MEM_REQ_O === 1'b1 && MEM_ACK_I === 1'b1) begin
            if (ref_q.size() == 0) begin
                check({MEM_WE_O, MEM_ADDR_O}, 18'h3FFFF);
            end else begin
                check({MEM_WE_O, MEM_ADDR_O}, ref_q.pop_front());
            end
        end
    end
    task automatic run(input logic [5:0] f, input logic [5:0] d);
        logic [15:0] r;
        logic [11:0] p, m, x, o, ea;
        logic [17:0] acc;
        int          t;
        r = step(); p = {4'h8, r[7:0]}; m = {3'h1, r[15:7]};
        r = step(); x = r[0] ? 12'hFFE : {4'h0, r[8:1]}; o = r[15:4];
        r = step(); acc = {r[5:0], r[15:4]};
        // address areas kept apart so no reference overwrites another
        ea = (d == 6'h00) ? m : a12(m, x);
        u_mem.words[{6'h00, d}] = x;
        u_mem.words[p] = m;
        u_mem.words[ea] = o;
        u_mem.words[p + 12'h001] = ~p;
        @(posedge CLK_I); ACC_WR_I <= 1'b1; ACC_DATA_I <= acc; mem_wait <= r[1:0];
        @(posedge CLK_I); ACC_WR_I <= 1'b0; START_I <= 1'b1; INSTR_I <= {f, d}; PADDR_I <= p;
        @(posedge CLK_I); START_I <= 1'b0;
        @(negedge CLK_I);
        if (f < 6'h2A || f > 6'h2F || (f == 6'h2F && d != 6'h00)) begin
            check(UNSUPPORTED_O, 18'h1);
            check(MEM_REQ_O, 18'h0);
            return;
        end
        // expected references; the first ack cannot come before the next edge
        ref_q.push_back({1'b0, p});
        if (d != 6'h00) ref_q.push_back({7'h00, d});
        ref_q.push_back({f == 6'h2C, ea});
        if (f >= 6'h2D) ref_q.push_back({1'b1, ea});
        ref_q.push_back({1'b0, p + 12'h001});
        case (f)
            6'h2A: acc = a18(acc, {6'h3F, ~o});
            6'h2B: acc[11:0] = acc[11:0] ^ o;
            6'h2D: acc = a18(acc, {6'h00, o});
            6'h2E: acc = a18(18'h00001, {6'h00, o});
            6'h2F: acc = a18(18'h3FFFE, {6'h00, o});
            default: acc = acc;
        endcase
        if (f == 6'h2E) check(ACC_O, 18'h00001);
        if (f == 6'h2F) check(ACC_O, 18'h3FFFE);
        for (t = 0; t < 100 && DONE_O !== 1'b1; t++) @(negedge CLK_I);
        if (t == 100) begin
            errors++;
            $display("mismatch at %0t: no completion", $time);
            hung = 1'b1;
            return;
        end
        check(ACC_O, acc);
        check(18'(REF_COUNT_O), 18'(3 + (d != 0) + (f >= 6'h2D)));
        check(u_mem.words[ea], (f >= 6'h2C) ? acc[11:0] : o);
        check(NEXT_INSTR_O, {6'h00, ~p});
        check(18'(ref_q.size()), 18'h0);
        ref_q.delete();
        check(LAST_OP_O, f - 6'h2A);
    endtask
    initial begin
        logic [15:0] r;
        RST_I = 1'b1; START_I = 1'b0; ACC_WR_I = 1'b0; INSTR_I = 12'h000;
        PADDR_I = 12'h000; ACC_DATA_I = 18'h00000; mem_wait = 2'h0;
        seed = 16'h0025; errors = 0; cmp_count = 0;
        hung = 1'b0;
        repeat (5) @(posedge CLK_I);
        RST_I <= 1'b0;
        // both edges of the group's code range, direct and indexed
        for (int i = 0; i < 24 && !hung; i++) begin
            for (logic [5:0] f = 6'h29; f <= 6'h30 && !hung; f++) begin
                r = step();
                run(f, i[0] ? {r[5:1], 1'b1} : 6'h00);
            end
        end
        summarize();
    end
endmodule // tb
`default_nettype wire
